// >>> cem_charger_event_mask_regs.svh
`ifndef CEM_CHARGER_EVENT_MASK_REGS_SVH
`define CEM_CHARGER_EVENT_MASK_REGS_SVH

// Register offsets on the serial control port
`define CEM_MASK_C_OFFSET 8'h2A
`define CEM_MASK_T_OFFSET 8'h2B

// Reset values
`define CEM_MASK_C_RESET 8'h00
`define CEM_MASK_T_RESET 8'h00

// Writable bits; all others read as zero
`define CEM_MASK_C_WMASK 8'h7F
`define CEM_MASK_T_WMASK 8'h1F

// Field positions in charger_event_mask_c
`define CEM_DETECT_DONE_BIT 6
`define CEM_CONV_DONE_BIT 5
`define CEM_SYSMIN_BIT 4
`define CEM_FAST_TMR_BIT 3
`define CEM_TRICKLE_TMR_BIT 2
`define CEM_PRECHG_TMR_BIT 1
`define CEM_TOPOFF_TMR_BIT 0

// Field positions in battery_thermal_event_mask
`define CEM_OTG_LOWBAT_BIT 4
`define CEM_THERM_COLD_BIT 3
`define CEM_THERM_COOL_BIT 2
`define CEM_THERM_WARM_BIT 1
`define CEM_THERM_HOT_BIT 0

// Second register sits in the upper byte of the event vector
`define CEM_T_BASE 8

// Default host alert pulse length in sys_clk cycles
`define CEM_ALERT_CYCLES 4

`endif

// >>> cem_pkg.sv
package cem_pkg;

  typedef logic [7:0] cem_byte_t;

  // Bit i of the low byte pairs with bit i of the first mask register,
  // bit i of the high byte with bit i of the second one.
  typedef logic [15:0] cem_event_vec_t;

  typedef enum logic [0:0] {
    CEM_ALERT_IDLE,
    CEM_ALERT_DRIVE
  } cem_alert_state_t;

endpackage

// >>> cem_mask_if.sv
`timescale 1ns/1ps
interface cem_mask_if;
  cem_pkg::cem_byte_t wdata;
  logic wr_c;
  logic wr_t;
  logic clr_c;
  logic clr_t;
  cem_pkg::cem_byte_t mask_c;
  cem_pkg::cem_byte_t mask_t;

  modport ctrl (
    output wdata,
    output wr_c,
    output wr_t,
    output clr_c,
    output clr_t,
    input mask_c,
    input mask_t
  );

  modport store (
    input wdata,
    input wr_c,
    input wr_t,
    input clr_c,
    input clr_t,
    output mask_c,
    output mask_t
  );
endinterface

// >>> cem_mask_store.sv
`timescale 1ns/1ps
`include "cem_charger_event_mask_regs.svh"
module cem_mask_store (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic clk_en, // Freezes state when low
  cem_mask_if.store mif // Mask storage port
);

  cem_pkg::cem_byte_t mask_c_reg;
  cem_pkg::cem_byte_t mask_c_next;
  cem_pkg::cem_byte_t mask_t_reg;
  cem_pkg::cem_byte_t mask_t_next;

  // Clear beats a same-cycle write: reset command means defaults
  always_comb begin
    mask_c_next = mask_c_reg;
    mask_t_next = mask_t_reg;
    if (mif.clr_c) begin
      mask_c_next = `CEM_MASK_C_RESET;
    end else if (mif.wr_c) begin
      mask_c_next = mif.wdata & `CEM_MASK_C_WMASK;
    end
    if (mif.clr_t) begin
      mask_t_next = `CEM_MASK_T_RESET;
    end else if (mif.wr_t) begin
      mask_t_next = mif.wdata & `CEM_MASK_T_WMASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_c_reg <= `CEM_MASK_C_RESET;
      mask_t_reg <= `CEM_MASK_T_RESET;
    end else if (clk_en) begin
      mask_c_reg <= mask_c_next;
      mask_t_reg <= mask_t_next;
    end
  end

  assign mif.mask_c = mask_c_reg;
  assign mif.mask_t = mask_t_reg;

endmodule

// >>> cem_alert_gen.sv
`timescale 1ns/1ps
`include "cem_charger_event_mask_regs.svh"
module cem_alert_gen #(
  parameter int ALERT_CYCLES = `CEM_ALERT_CYCLES
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic clk_en, // Freezes state when low
  input wire cem_pkg::cem_event_vec_t events, // One-cycle event pulses
  input wire cem_pkg::cem_event_vec_t masks, // 1 suppresses the event
  output logic alert_pulse // Host alert pulse
);

  localparam int CW = $clog2(ALERT_CYCLES + 1);

  if (ALERT_CYCLES < 1 || ALERT_CYCLES > 255) begin : g_bad_alert_cycles
    $error("ALERT_CYCLES out of range");
  end

  cem_pkg::cem_alert_state_t state_reg;
  cem_pkg::cem_alert_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic alert_reg;
  logic alert_next;
  logic fire;

  // Masking only gates this path; flags are kept elsewhere
  assign fire = |(events & ~masks);

  // A new event during a pulse restarts its length, so back-to-back
  // events merge into one longer pulse rather than being dropped.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    alert_next = alert_reg;
    case (state_reg)
      cem_pkg::CEM_ALERT_IDLE: begin
        if (fire) begin
          state_next = cem_pkg::CEM_ALERT_DRIVE;
          cnt_next = CW'(ALERT_CYCLES - 1);
          alert_next = 1'b1;
        end
      end
      cem_pkg::CEM_ALERT_DRIVE: begin
        if (fire) begin
          cnt_next = CW'(ALERT_CYCLES - 1);
        end else if (cnt_reg == '0) begin
          state_next = cem_pkg::CEM_ALERT_IDLE;
          alert_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - CW'(1);
        end
      end
      default: begin
        state_next = cem_pkg::CEM_ALERT_IDLE;
        cnt_next = '0;
        alert_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= cem_pkg::CEM_ALERT_IDLE;
      cnt_reg <= '0;
      alert_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      alert_reg <= alert_next;
    end
  end

  assign alert_pulse = alert_reg;

endmodule

// >>> cem_charger_event_mask_bank.sv
// What this block does
// - Detection-done event alerts the host unless bit 6 suppresses it.
// - Conversion-done event alerts the host unless bit 5 suppresses it.
// - Entry and exit of minimum system regulation alert unless bit 4 set.
// - Fast charge timer expiry alerts the host unless bit 3 set.
// - Trickle charge timer expiry alerts the host unless bit 2 set.
// - Pre-charge timer expiry alerts the host unless bit 1 set.
// - Top-off timer expiry alerts the host unless bit 0 set.
// - Battery too low for OTG alerts unless second register bit 4 set.
// - Thermistor cold crossing alerts unless second register bit 3 set.
// - Thermistor cool crossing alerts unless second register bit 2 set.
// - Thermistor warm crossing alerts unless second register bit 1 set.
// - Thermistor hot crossing alerts unless second register bit 0 set.
// - Both masks read zero at power-on; reset command clears the first.
// - Second mask clears on reset command and on watchdog expiry.
`timescale 1ns/1ps
`include "cem_charger_event_mask_regs.svh"
module cem_charger_event_mask_bank #(
  parameter int ALERT_CYCLES = `CEM_ALERT_CYCLES
) (
  input wire logic sys_clk, // 250 MHz system clock
  input wire logic rst, // Async reset, high
  input wire logic clk_en, // Freezes all state when low
  input wire logic [7:0] reg_addr, // Register address
  input wire cem_pkg::cem_byte_t reg_wdata, // Write data
  input wire logic reg_wr_en, // Write strobe, one cycle
  input wire logic reg_rd_en, // Read strobe, one cycle
  output cem_pkg::cem_byte_t reg_rdata, // Read data, registered
  output logic reg_rd_valid, // Read data valid pulse
  input wire logic reg_reset_cmd, // Register reset command pulse
  input wire logic watchdog_expired, // Host watchdog expiry pulse
  input wire logic evt_detect_done, // D+/D- detection done pulse
  input wire logic evt_conversion_done, // Conversion done pulse
  input wire logic sysmin_regulating, // Level: in minimum system regulation
  input wire logic evt_fast_timer, // Fast charge timer expired pulse
  input wire logic evt_trickle_timer, // Trickle timer expired pulse
  input wire logic evt_precharge_timer, // Pre-charge timer expired pulse
  input wire logic evt_topoff_timer, // Top-off timer expired pulse
  input wire logic evt_otg_lowbat, // Battery below OTG threshold pulse
  input wire logic evt_therm_cold, // Thermistor crossed T1 pulse
  input wire logic evt_therm_cool, // Thermistor crossed T2 pulse
  input wire logic evt_therm_warm, // Thermistor crossed T3 pulse
  input wire logic evt_therm_hot, // Thermistor crossed T5 pulse
  input wire cem_pkg::cem_event_vec_t flag_clear, // Per-event flag clear pulses
  output cem_pkg::cem_event_vec_t event_flags, // Sticky event flags, registered
  output logic host_alert_pulse // Host alert output
);

  // Pulse counter and checker shadow are sized for at most 255 cycles
  if (ALERT_CYCLES < 1 || ALERT_CYCLES > 255) begin : g_bad_alert_cycles
    $error("ALERT_CYCLES out of range");
  end

  // A field on a non-writable bit would leave its event stuck unmasked
  localparam logic [7:0] C_FIELDS = (8'h01 << `CEM_DETECT_DONE_BIT)
    | (8'h01 << `CEM_CONV_DONE_BIT)
    | (8'h01 << `CEM_SYSMIN_BIT)
    | (8'h01 << `CEM_FAST_TMR_BIT)
    | (8'h01 << `CEM_TRICKLE_TMR_BIT)
    | (8'h01 << `CEM_PRECHG_TMR_BIT)
    | (8'h01 << `CEM_TOPOFF_TMR_BIT);

  localparam logic [7:0] T_FIELDS = (8'h01 << `CEM_OTG_LOWBAT_BIT)
    | (8'h01 << `CEM_THERM_COLD_BIT)
    | (8'h01 << `CEM_THERM_COOL_BIT)
    | (8'h01 << `CEM_THERM_WARM_BIT)
    | (8'h01 << `CEM_THERM_HOT_BIT);

  if ((C_FIELDS & ~`CEM_MASK_C_WMASK) != 8'h00) begin : g_bad_c_fields
    $error("First mask field outside its writable bits");
  end

  if ((T_FIELDS & ~`CEM_MASK_T_WMASK) != 8'h00) begin : g_bad_t_fields
    $error("Second mask field outside its writable bits");
  end

  if (`CEM_MASK_C_OFFSET == `CEM_MASK_T_OFFSET) begin : g_same_offset
    $error("Mask registers share one offset");
  end

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  // Reserved bits read zero even if storage ever held them
  function automatic cem_pkg::cem_byte_t read_view(input cem_pkg::cem_byte_t stored,
                                                  input cem_pkg::cem_byte_t wmask);
    read_view = stored & wmask;
  endfunction

  cem_mask_if mif ();

  // Register port decode

  logic hit_c;
  logic hit_t;

  assign hit_c = addr_is(reg_addr, `CEM_MASK_C_OFFSET);
  assign hit_t = addr_is(reg_addr, `CEM_MASK_T_OFFSET);

  assign mif.wdata = reg_wdata;
  assign mif.wr_c = reg_wr_en & hit_c;
  assign mif.wr_t = reg_wr_en & hit_t;
  assign mif.clr_c = reg_reset_cmd;
  assign mif.clr_t = reg_reset_cmd | watchdog_expired;

  cem_mask_store u_store (
    .sys_clk (sys_clk),
    .rst (rst),
    .clk_en (clk_en),
    .mif (mif)
  );

  // Named mask fields

  logic detect_done_suppress;
  logic conversion_done_suppress;
  logic sysmin_reg_suppress;
  logic fast_timer_suppress;
  logic trickle_timer_suppress;
  logic precharge_timer_suppress;
  logic topoff_timer_suppress;
  logic otg_lowbat_suppress;
  logic thermistor_cold_suppress;
  logic thermistor_cool_suppress;
  logic thermistor_warm_suppress;
  logic thermistor_hot_suppress;

  assign detect_done_suppress = mif.mask_c[`CEM_DETECT_DONE_BIT];
  assign conversion_done_suppress = mif.mask_c[`CEM_CONV_DONE_BIT];
  assign sysmin_reg_suppress = mif.mask_c[`CEM_SYSMIN_BIT];
  assign fast_timer_suppress = mif.mask_c[`CEM_FAST_TMR_BIT];
  assign trickle_timer_suppress = mif.mask_c[`CEM_TRICKLE_TMR_BIT];
  assign precharge_timer_suppress = mif.mask_c[`CEM_PRECHG_TMR_BIT];
  assign topoff_timer_suppress = mif.mask_c[`CEM_TOPOFF_TMR_BIT];
  assign otg_lowbat_suppress = mif.mask_t[`CEM_OTG_LOWBAT_BIT];
  assign thermistor_cold_suppress = mif.mask_t[`CEM_THERM_COLD_BIT];
  assign thermistor_cool_suppress = mif.mask_t[`CEM_THERM_COOL_BIT];
  assign thermistor_warm_suppress = mif.mask_t[`CEM_THERM_WARM_BIT];
  assign thermistor_hot_suppress = mif.mask_t[`CEM_THERM_HOT_BIT];

  // Read path

  cem_pkg::cem_byte_t rdata_reg;
  cem_pkg::cem_byte_t rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // Unmapped addresses read zero; reserved bits are zero in storage
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (reg_rd_en) begin
      rvalid_next = 1'b1;
      if (hit_c) begin
        rdata_next = read_view(mif.mask_c, `CEM_MASK_C_WMASK);
      end else if (hit_t) begin
        rdata_next = read_view(mif.mask_t, `CEM_MASK_T_WMASK);
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rvalid_reg;

  // Minimum system regulation edges

  logic sysmin_prev_reg;
  logic sysmin_prev_next;
  logic sysmin_edge;
  logic sysmin_entry;
  logic sysmin_exit;

  // Previous level starts low, so a level already high at release
  // counts as one entry.
  always_comb begin
    sysmin_prev_next = sysmin_regulating;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sysmin_prev_reg <= 1'b0;
    end else if (clk_en) begin
      sysmin_prev_reg <= sysmin_prev_next;
    end
  end

  assign sysmin_entry = sysmin_regulating & ~sysmin_prev_reg;
  assign sysmin_exit = ~sysmin_regulating & sysmin_prev_reg;
  assign sysmin_edge = sysmin_entry | sysmin_exit;

  // Event vector, aligned bit for bit with the two mask registers

  cem_pkg::cem_event_vec_t events;
  cem_pkg::cem_event_vec_t masks;

  always_comb begin
    events = '0;
    events[`CEM_DETECT_DONE_BIT] = evt_detect_done;
    events[`CEM_CONV_DONE_BIT] = evt_conversion_done;
    events[`CEM_SYSMIN_BIT] = sysmin_edge;
    events[`CEM_FAST_TMR_BIT] = evt_fast_timer;
    events[`CEM_TRICKLE_TMR_BIT] = evt_trickle_timer;
    events[`CEM_PRECHG_TMR_BIT] = evt_precharge_timer;
    events[`CEM_TOPOFF_TMR_BIT] = evt_topoff_timer;
    events[`CEM_T_BASE + `CEM_OTG_LOWBAT_BIT] = evt_otg_lowbat;
    events[`CEM_T_BASE + `CEM_THERM_COLD_BIT] = evt_therm_cold;
    events[`CEM_T_BASE + `CEM_THERM_COOL_BIT] = evt_therm_cool;
    events[`CEM_T_BASE + `CEM_THERM_WARM_BIT] = evt_therm_warm;
    events[`CEM_T_BASE + `CEM_THERM_HOT_BIT] = evt_therm_hot;
  end

  // Reserved positions stay zero, so no stray bit can suppress anything
  always_comb begin
    masks = '0;
    masks[`CEM_DETECT_DONE_BIT] = detect_done_suppress;
    masks[`CEM_CONV_DONE_BIT] = conversion_done_suppress;
    masks[`CEM_SYSMIN_BIT] = sysmin_reg_suppress;
    masks[`CEM_FAST_TMR_BIT] = fast_timer_suppress;
    masks[`CEM_TRICKLE_TMR_BIT] = trickle_timer_suppress;
    masks[`CEM_PRECHG_TMR_BIT] = precharge_timer_suppress;
    masks[`CEM_TOPOFF_TMR_BIT] = topoff_timer_suppress;
    masks[`CEM_T_BASE + `CEM_OTG_LOWBAT_BIT] = otg_lowbat_suppress;
    masks[`CEM_T_BASE + `CEM_THERM_COLD_BIT] = thermistor_cold_suppress;
    masks[`CEM_T_BASE + `CEM_THERM_COOL_BIT] = thermistor_cool_suppress;
    masks[`CEM_T_BASE + `CEM_THERM_WARM_BIT] = thermistor_warm_suppress;
    masks[`CEM_T_BASE + `CEM_THERM_HOT_BIT] = thermistor_hot_suppress;
  end

  // Sticky flags, unaffected by masks

  cem_pkg::cem_event_vec_t flags_reg;
  cem_pkg::cem_event_vec_t flags_next;

  // A set arriving with its clear survives
  always_comb begin
    flags_next = (flags_reg & ~flag_clear) | events;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= '0;
    end else if (clk_en) begin
      flags_reg <= flags_next;
    end
  end

  assign event_flags = flags_reg;

  // Alert pulse

  cem_alert_gen #(
    .ALERT_CYCLES (ALERT_CYCLES)
  ) u_alert (
    .sys_clk (sys_clk),
    .rst (rst),
    .clk_en (clk_en),
    .events (events),
    .masks (masks),
    .alert_pulse (host_alert_pulse)
  );

endmodule

// >>> cem_bank_sva.sv
`timescale 1ns/1ps
module cem_bank_sva #(
  parameter int ALERT_CYCLES = 4
) (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic clk_en, // enable
  input wire logic [7:0] reg_addr, // address
  input wire cem_pkg::cem_byte_t reg_wdata, // write data
  input wire logic reg_wr_en, // write strobe
  input wire logic reg_rd_en, // read strobe
  input wire cem_pkg::cem_byte_t reg_rdata, // read data
  input wire logic reg_rd_valid, // read valid
  input wire logic reg_reset_cmd, // reset command
  input wire logic watchdog_expired, // watchdog
  input wire logic evt_detect_done, // event
  input wire logic evt_conversion_done, // event
  input wire logic sysmin_regulating, // level
  input wire logic evt_fast_timer, // event
  input wire logic evt_trickle_timer, // event
  input wire logic evt_precharge_timer, // event
  input wire logic evt_topoff_timer, // event
  input wire logic evt_otg_lowbat, // event
  input wire logic evt_therm_cold, // event
  input wire logic evt_therm_cool, // event
  input wire logic evt_therm_warm, // event
  input wire logic evt_therm_hot, // event
  input wire cem_pkg::cem_event_vec_t event_flags, // flags
  input wire logic host_alert_pulse // alert
);
  logic [7:0] sc_reg, st_reg, cnt_reg, rsel;
  logic prev_reg;
  logic [15:0] ev, um;
  // Shadow masks rebuilt from port traffic, since the real ones are internal
  assign ev = {3'h0, evt_otg_lowbat, evt_therm_cold, evt_therm_cool, evt_therm_warm,
    evt_therm_hot, 1'b0, evt_detect_done, evt_conversion_done, sysmin_regulating ^ prev_reg,
    evt_fast_timer, evt_trickle_timer, evt_precharge_timer, evt_topoff_timer};
  assign um = ev & ~{st_reg, sc_reg};
  assign rsel = reg_addr == 8'h2A ? sc_reg : (reg_addr == 8'h2B ? st_reg : 8'h00);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sc_reg <= 8'h00;
      st_reg <= 8'h00;
      cnt_reg <= 8'h00;
      prev_reg <= 1'b0;
    end else if (clk_en) begin
      prev_reg <= sysmin_regulating;
      if (reg_reset_cmd) sc_reg <= 8'h00;
      else if (reg_wr_en && reg_addr == 8'h2A) sc_reg <= reg_wdata & 8'h7F;
      if (reg_reset_cmd || watchdog_expired) st_reg <= 8'h00;
      else if (reg_wr_en && reg_addr == 8'h2B) st_reg <= reg_wdata & 8'h1F;
      if (|um) cnt_reg <= 8'(ALERT_CYCLES);
      else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wd;
    clk_en && watchdog_expired ##1 !reg_wr_en ##1 clk_en && reg_rd_en && reg_addr == 8'h2B;
  endsequence
  sequence s_rc;
    clk_en && reg_reset_cmd ##1 !reg_wr_en ##1 clk_en && reg_rd_en && reg_addr == 8'h2A;
  endsequence
  property p_alert_window;
    host_alert_pulse == (cnt_reg != 8'h00);
  endproperty
  property p_c_alert;
    clk_en && |um[6:0] |=> host_alert_pulse;
  endproperty
  property p_t_alert;
    clk_en && |um[12:8] |=> host_alert_pulse;
  endproperty
  property p_flags_set;
    clk_en && ev != 16'h0000 |=> (event_flags & $past(ev)) == $past(ev);
  endproperty
  property p_rd_valid;
    clk_en && reg_rd_en |=> reg_rd_valid;
  endproperty
  property p_no_valid;
    clk_en && !reg_rd_en |=> !reg_rd_valid;
  endproperty
  property p_rd_data;
    clk_en && reg_rd_en |=> reg_rdata == $past(rsel);
  endproperty
  property p_wd_clear;
    s_wd |=> reg_rdata == 8'h00;
  endproperty
  property p_rc_clear;
    s_rc |=> reg_rdata == 8'h00;
  endproperty
  a_alert_window: assert property (p_alert_window) else $error("alert length off");
  a_c_alert: assert property (p_c_alert) else $error("no alert");
  a_t_alert: assert property (p_t_alert) else $error("no alert");
  a_flags_set: assert property (p_flags_set) else $error("flag not set");
  a_rd_valid: assert property (p_rd_valid) else $error("no read valid");
  a_no_valid: assert property (p_no_valid) else $error("stray read valid");
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear missed");
  a_rc_clear: assert property (p_rc_clear) else $error("reset clear missed");
endmodule
bind cem_charger_event_mask_bank cem_bank_sva #(.ALERT_CYCLES(ALERT_CYCLES)) chk (
  .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .reg_reset_cmd(reg_reset_cmd),
  .watchdog_expired(watchdog_expired), .evt_detect_done(evt_detect_done),
  .evt_conversion_done(evt_conversion_done), .sysmin_regulating(sysmin_regulating),
  .evt_fast_timer(evt_fast_timer), .evt_trickle_timer(evt_trickle_timer),
  .evt_precharge_timer(evt_precharge_timer), .evt_topoff_timer(evt_topoff_timer),
  .evt_otg_lowbat(evt_otg_lowbat), .evt_therm_cold(evt_therm_cold),
  .evt_therm_cool(evt_therm_cool), .evt_therm_warm(evt_therm_warm),
  .evt_therm_hot(evt_therm_hot), .event_flags(event_flags),
  .host_alert_pulse(host_alert_pulse)
);

// >>> cem_host_model.sv
`timescale 1ns/1ps
module cem_host_model (
  input wire logic sys_clk, // clock
  output logic [7:0] reg_addr, // address
  output cem_pkg::cem_byte_t reg_wdata, // write data
  output logic reg_wr_en, // write strobe
  output logic reg_rd_en, // read strobe
  input wire cem_pkg::cem_byte_t reg_rdata, // read data
  input wire logic reg_rd_valid // read valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd,
                      output logic [7:0] q);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = !rd;
    reg_rd_en = rd;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    // Idle bus shows junk, not the last value
    reg_addr = ~a;
    reg_wdata = ~d;
    q = (rd && reg_rd_valid !== 1'b1) ? 8'hXX : reg_rdata;
  endtask
endmodule

// >>> cem_charger_event_mask_bank_bench.sv
`timescale 1ns/1ps
module cem_charger_event_mask_bank_bench;
  localparam int AC = 3;
  logic sys_clk = 1'b0, rst = 1'b1, rcmd = 1'b0, wdog = 1'b0, sysmin = 1'b0, ce = 1'b1;
  logic [15:0] ev_drv = 16'h0000, fclr = 16'h0000, flags;
  logic [7:0] addr, wdata, rdata, q;
  logic wr_en, rd_en, rd_valid, alert;
  int miscompares = 0, n_tests = 0, cycles = 0, mc = 0, mt = 0;
  int pos[12] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 12};
  initial forever #2 sys_clk = ~sys_clk;
  cem_host_model host (.sys_clk(sys_clk), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_rdata(rdata), .reg_rd_valid(rd_valid));
  cem_charger_event_mask_bank #(.ALERT_CYCLES(AC)) dut (.sys_clk(sys_clk), .rst(rst),
    .clk_en(ce), .reg_addr(addr), .reg_wdata(wdata), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_rdata(rdata), .reg_rd_valid(rd_valid), .reg_reset_cmd(rcmd),
    .watchdog_expired(wdog), .evt_detect_done(ev_drv[6]), .evt_conversion_done(ev_drv[5]),
    .sysmin_regulating(sysmin), .evt_fast_timer(ev_drv[3]), .evt_trickle_timer(ev_drv[2]),
    .evt_precharge_timer(ev_drv[1]), .evt_topoff_timer(ev_drv[0]),
    .evt_otg_lowbat(ev_drv[12]), .evt_therm_cold(ev_drv[11]), .evt_therm_cool(ev_drv[10]),
    .evt_therm_warm(ev_drv[9]), .evt_therm_hot(ev_drv[8]), .flag_clear(fclr),
    .event_flags(flags), .host_alert_pulse(alert));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input int exp);
    host.xfer(a, 8'h00, 1'b1, q);
    chk({8'h00, q}, 16'(exp));
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  // Sysmin is a level, so each call flips it: entry and exit both get exercised
  task automatic fire(input int i, input logic [15:0] m);
    @(negedge sys_clk);
    if (i == 4) sysmin = ~sysmin;
    else ev_drv[i] = 1'b1;
    @(negedge sys_clk);
    ev_drv = 16'h0000;
    chk({15'h0, alert}, {15'h0, !m[i]});
    chk(flags, 16'h0001 << i);
    fclr = 16'hFFFF;
    @(negedge sys_clk);
    fclr = 16'h0000;
    repeat (AC - 1) @(negedge sys_clk);
    chk({15'h0, alert}, 16'h0000);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    logic [15:0] m;
    int k;
    k = $urandom(1652);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    for (k = 0; k < 3; k++) rd_chk(8'h2A + 8'(k), 0);
    // Two open rounds, then two masked: sysmin entry and exit meet both
    for (k = 0; k < 48; k++) begin
      m = 16'($urandom);
      m[pos[k % 12]] = k >= 24;
      host.xfer(8'h2A, m[7:0], 1'b0, q);
      host.xfer(8'h2B, m[15:8], 1'b0, q);
      mc = m[7:0] & 8'h7F;
      mt = m[15:8] & 8'h1F;
      rd_chk(8'h2A, mc);
      rd_chk(8'h2B, mt);
      fire(pos[k % 12], m);
    end
    host.xfer(8'h2A, 8'hFF, 1'b0, q);
    host.xfer(8'h2B, 8'hFF, 1'b0, q);
    pulse(wdog);
    mt = 0;
    rd_chk(8'h2B, mt);
    rd_chk(8'h2A, 8'h7F);
    host.xfer(8'h2B, 8'hFF, 1'b0, q);
    pulse(rcmd);
    mc = 0;
    rd_chk(8'h2A, mc);
    rd_chk(8'h2B, mt);
    // Frozen clock enable: write and event are both lost
    ce = 1'b0;
    host.xfer(8'h2A, 8'h7F, 1'b0, q);
    ev_drv[0] = 1'b1;
    @(negedge sys_clk);
    ev_drv = 16'h0000;
    ce = 1'b1;
    chk({alert, flags[14:0]}, 16'h0000);
    rd_chk(8'h2A, mc);
    complete_run();
  end
endmodule
